// >>> hdl/slp_pkg.sv
package slp_pkg;

  // access byte fields
  localparam int AB_PRESENT = 7;
  localparam int AB_LVL_HI = 6;
  localparam int AB_LVL_LO = 5;
  localparam int AB_SEG = 4;
  localparam int AB_EXEC = 3;
  localparam int AB_CONF_DOWN = 2;
  localparam int AB_RW = 1;
  localparam int AB_ACC = 0;

  // segment register indices
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CS = 2'h1;
  localparam logic [1:0] SEG_SS = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;

  // reset contents of the segment caches
  localparam logic [7:0] ACC_RST_CODE = 8'h9B;
  localparam logic [7:0] ACC_RST_DATA = 8'h93;
  localparam logic [15:0] LIM_RST = 16'hFFFF;
  localparam logic [15:0] SEL_RST = 16'h0000;

  // register byte offsets on the bus
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CODE_STACK = 8'h08;
  localparam logic [7:0] REG_DATA_EXTRA = 8'h0C;
  localparam int CTRL_PROT_EN = 0;
  localparam logic CTRL_RST = 1'b1;
  localparam int STAT_CNT_LO = 16;

  // fault causes, reported in status bits 2:0
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_TYPE = 3'h1;
  localparam logic [2:0] CAUSE_PRIV = 3'h2;
  localparam logic [2:0] CAUSE_LIMIT = 3'h3;
  localparam logic [2:0] CAUSE_READ = 3'h4;
  localparam logic [2:0] CAUSE_WRITE = 3'h5;
  localparam logic [2:0] CAUSE_XFER = 3'h6;

  typedef enum logic [1:0] {OP_NONE, OP_LOAD, OP_ACCESS, OP_XFER} slp_op_type;
  typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_EXEC, ACC_FETCH}
    slp_acc_type;
  typedef enum logic [1:0] {XF_JUMP, XF_CALL, XF_RET} slp_xfer_type;

  typedef struct packed {
    logic valid;
    slp_op_type op;
    logic [1:0] seg;
    logic [15:0] selector;
    logic [7:0] access;
    logic [15:0] limit;
    logic [15:0] offset;
    slp_acc_type acc;
    slp_xfer_type xfer;
  } slp_req_type;

  typedef struct packed {
    logic done;
    logic fault;
    logic err_sel;
    logic [15:0] err_code;
    logic proceed;
    logic mark_accessed;
    logic [15:0] mark_selector;
    logic [1:0] current_level;
  } slp_rsp_type;

endpackage : slp_pkg

// >>> hdl/slp_check.sv
// Summary of operation
// - data or extra register loads check access byte; failure reports selector.
// - data/extra take data or execute-read; stack read-write data; code code.
// - data loads need descriptor_level at least current_level, else selector fault.
// - stack load faults unless descriptor_level equals current_level.
// - every access offset checked against limit; a read, write or execute violation faults with zero.
// - expand_down clear allows offsets zero through limit inclusive.
// - expand_down set allows limit plus one through 0FFFFH.
// - stack load needs no expand_down; expand-down data fits data/extra.
// - checks finish before memory reference; no update on a faulting push.
// - reads of execute-only code fault with error code zero.
// - executable descriptor loads into data/extra only when readable.
// - every write into a code segment faults with error code zero.
// - executing past code limit faults; prefetch past it never faults.
// - direct jump or call to non-conforming code needs equal levels.
// - returns only to same or lesser privilege; inward only through gates.
// - conforming code accepts transfer from numerically greater current_level.
// - current_level lives in low two bits of code and stack registers.
// - descriptor_level is access byte bits five and six.
// - requested_level above descriptor_level denies the load.
// - effective_level is max of current and requested; must not exceed descriptor_level.
// - bit 3 executable, bit 2 conforming or expand_down, bit 1 read/write.
// - bit 7 present, bit 4 segment descriptor; type checks need bit 4.
// - every successful load sets the descriptor's accessed bit.
`timescale 1ns/100ps
module slp_check (
  input wire logic clk_i, // processor clock
  input wire logic rst_i, // synchronous reset, active high
  input wire slp_pkg::slp_req_type req_i, // check request, one-cycle valid
  output slp_pkg::slp_rsp_type rsp_o, // check answer, one cycle later
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic wb_ack_o, // wishbone acknowledge
  output logic [31:0] wb_dat_o // wishbone read data
);

  logic [15:0] seg_sel_q [4];
  logic [7:0] seg_acc_q [4];
  logic [15:0] seg_lim_q [4];
  slp_pkg::slp_rsp_type rsp_q;
  logic prot_en_q;
  logic [2:0] cause_q;
  logic [15:0] fault_cnt_q;
  logic ack_q;
  logic [31:0] dat_q;

  logic [1:0] current_level;
  logic [1:0] descriptor_level;
  logic [1:0] requested_level;
  logic [1:0] effective_level;
  logic [1:0] new_lvl_d;
  logic [7:0] c_acc;
  logic [15:0] c_lim;
  logic expand_down;
  logic in_range;
  logic fetch_ok;
  logic [2:0] cause_d;
  logic fault_d;
  logic commit_d;
  logic wb_wr;

  // lesser privilege of two levels
  function automatic logic [1:0] max_level(input logic [1:0] a,
                                           input logic [1:0] b);
    max_level = (a > b) ? a : b;
  endfunction : max_level

  // legal descriptor type for a target register
  function automatic logic type_ok(input logic [1:0] seg,
                                   input logic [7:0] ab);
    logic code;
    logic rw;
    code = ab[slp_pkg::AB_EXEC];
    rw = ab[slp_pkg::AB_RW];
    if (!ab[slp_pkg::AB_PRESENT] || !ab[slp_pkg::AB_SEG])
      type_ok = 1'b0;
    else if (seg == slp_pkg::SEG_CS)
      type_ok = code;
    // stack needs writable data, expand_down either way
    else if (seg == slp_pkg::SEG_SS)
      type_ok = !code && rw;
    // code into data or extra only if readable
    else
      type_ok = !code || rw;
  endfunction : type_ok

  always_comb
  begin
    current_level = seg_sel_q[slp_pkg::SEG_CS][1:0];
    // level field of the access byte
    descriptor_level = req_i.access[slp_pkg::AB_LVL_HI:slp_pkg::AB_LVL_LO];
    requested_level = req_i.selector[1:0];
    effective_level = max_level(current_level, requested_level);
    c_acc = seg_acc_q[req_i.seg];
    c_lim = seg_lim_q[req_i.seg];
    // bit 2 is expand_down only for data
    expand_down = !c_acc[slp_pkg::AB_EXEC] && c_acc[slp_pkg::AB_CONF_DOWN];
    // normal range; all-ones limit wraps limit+1 to zero: full
    in_range = expand_down ? (req_i.offset > c_lim || &c_lim) :
               (req_i.offset <= c_lim);
    cause_d = slp_pkg::CAUSE_NONE;
    new_lvl_d = current_level;
    fetch_ok = 1'b1;
    case (req_i.op)
      slp_pkg::OP_LOAD:
      begin
        // type check on load; direct code loads go as transfers
        if (!type_ok(req_i.seg, req_i.access) ||
            req_i.seg == slp_pkg::SEG_CS)
          cause_d = slp_pkg::CAUSE_TYPE;
        else if (requested_level > descriptor_level)
          cause_d = slp_pkg::CAUSE_PRIV;
        else if (req_i.seg == slp_pkg::SEG_SS &&
                 descriptor_level != current_level)
          cause_d = slp_pkg::CAUSE_PRIV;
        // data and non-conforming readable code need level check
        else if (!(req_i.access[slp_pkg::AB_EXEC] &&
                   req_i.access[slp_pkg::AB_CONF_DOWN]) &&
                 effective_level > descriptor_level)
          cause_d = slp_pkg::CAUSE_PRIV;
      end
      slp_pkg::OP_XFER:
      begin
        if (!type_ok(slp_pkg::SEG_CS, req_i.access))
          cause_d = slp_pkg::CAUSE_TYPE;
        else if (req_i.xfer == slp_pkg::XF_RET)
        begin
          new_lvl_d = requested_level;
          if (requested_level < current_level)
            cause_d = slp_pkg::CAUSE_XFER;
          else if (req_i.access[slp_pkg::AB_CONF_DOWN] ?
                   (descriptor_level > requested_level) :
                   (descriptor_level != requested_level))
            cause_d = slp_pkg::CAUSE_XFER;
        end
        // conforming target may be more privileged
        else if (req_i.access[slp_pkg::AB_CONF_DOWN])
        begin
          if (descriptor_level > current_level)
            cause_d = slp_pkg::CAUSE_XFER;
        end
        else if (descriptor_level != current_level)
          cause_d = slp_pkg::CAUSE_XFER;
      end
      slp_pkg::OP_ACCESS:
      begin
        if (req_i.acc == slp_pkg::ACC_READ && c_acc[slp_pkg::AB_EXEC] &&
            !c_acc[slp_pkg::AB_RW])
          cause_d = slp_pkg::CAUSE_READ;
        // code is never writable; read-only data too
        else if (req_i.acc == slp_pkg::ACC_WRITE &&
                 (c_acc[slp_pkg::AB_EXEC] || !c_acc[slp_pkg::AB_RW]))
          cause_d = slp_pkg::CAUSE_WRITE;
        // prefetch past limit just does not proceed
        else if (req_i.acc == slp_pkg::ACC_FETCH)
          fetch_ok = in_range;
        else if (!in_range)
          cause_d = slp_pkg::CAUSE_LIMIT;
      end
      default:
        cause_d = slp_pkg::CAUSE_NONE;
    endcase
    // protection disabled: every check passes
    if (!prot_en_q)
    begin
      cause_d = slp_pkg::CAUSE_NONE;
      fetch_ok = 1'b1;
    end
    fault_d = req_i.valid && cause_d != slp_pkg::CAUSE_NONE;
    commit_d = req_i.valid && !fault_d &&
               (req_i.op == slp_pkg::OP_LOAD || req_i.op == slp_pkg::OP_XFER);
  end

  // segment register caches
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 4; i++)
      begin
        seg_sel_q[i] <= slp_pkg::SEL_RST;
        seg_lim_q[i] <= slp_pkg::LIM_RST;
        seg_acc_q[i] <= (i == 1) ? slp_pkg::ACC_RST_CODE :
                        slp_pkg::ACC_RST_DATA;
      end
    end
    // nothing is written when the check faults
    else if (commit_d && req_i.op == slp_pkg::OP_LOAD)
    begin
      // code and stack registers carry current_level
      // a code load commits only with checks off; the level must not move
      seg_sel_q[req_i.seg] <= (req_i.seg == slp_pkg::SEG_SS ||
                               req_i.seg == slp_pkg::SEG_CS) ?
                              {req_i.selector[15:2], current_level} :
                              req_i.selector;
      seg_acc_q[req_i.seg] <= req_i.access | 8'h01;
      seg_lim_q[req_i.seg] <= req_i.limit;
    end
    else if (commit_d)
    begin
      // new level lands in code and stack registers
      seg_sel_q[slp_pkg::SEG_CS] <= {req_i.selector[15:2], new_lvl_d};
      seg_sel_q[slp_pkg::SEG_SS][1:0] <= new_lvl_d;
      seg_acc_q[slp_pkg::SEG_CS] <= req_i.access | 8'h01;
      seg_lim_q[slp_pkg::SEG_CS] <= req_i.limit;
    end
  end

  // answer to the requester, registered
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rsp_q <= '0;
    else
    begin
      rsp_q.done <= req_i.valid;
      rsp_q.fault <= fault_d;
      // selector code on load and transfer, zero on access
      rsp_q.err_sel <= fault_d && req_i.op != slp_pkg::OP_ACCESS;
      rsp_q.err_code <= (fault_d && req_i.op != slp_pkg::OP_ACCESS) ?
                        req_i.selector : 16'h0000;
      // memory reference only after clean checks
      rsp_q.proceed <= req_i.valid && !fault_d && fetch_ok &&
                       req_i.op == slp_pkg::OP_ACCESS;
      // ask descriptor logic to set the accessed bit
      rsp_q.mark_accessed <= commit_d;
      rsp_q.mark_selector <= commit_d ? req_i.selector : 16'h0000;
      rsp_q.current_level <= commit_d ? new_lvl_d : current_level;
    end
  end

  assign rsp_o = rsp_q;

  // write lands at the edge where the master sees ack
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_q <= 32'h00000000;
    else if (wb_cyc_i && wb_stb_i && !ack_q)
    begin
      case (wb_adr_i)
        slp_pkg::REG_CTRL:
          dat_q <= {31'h00000000, prot_en_q};
        slp_pkg::REG_STATUS:
          dat_q <= {fault_cnt_q, 13'h0000, cause_q};
        slp_pkg::REG_CODE_STACK:
          dat_q <= {seg_sel_q[slp_pkg::SEG_SS], seg_sel_q[slp_pkg::SEG_CS]};
        slp_pkg::REG_DATA_EXTRA:
          dat_q <= {seg_sel_q[slp_pkg::SEG_EXTRA],
                    seg_sel_q[slp_pkg::SEG_DATA]};
        default:
          dat_q <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prot_en_q <= slp_pkg::CTRL_RST;
    else if (wb_wr && wb_adr_i == slp_pkg::REG_CTRL && wb_sel_i[0])
      prot_en_q <= wb_dat_i[slp_pkg::CTRL_PROT_EN];
  end

  // fault log; a fault in the clearing cycle survives the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fault_cnt_q <= 16'h0000;
      cause_q <= slp_pkg::CAUSE_NONE;
    end
    else if (fault_d)
    begin
      cause_q <= cause_d;
      if (wb_wr && wb_adr_i == slp_pkg::REG_STATUS)
        fault_cnt_q <= 16'h0001;
      else if (fault_cnt_q != 16'hFFFF)
        fault_cnt_q <= fault_cnt_q + 16'h0001;
    end
    else if (wb_wr && wb_adr_i == slp_pkg::REG_STATUS)
    begin
      fault_cnt_q <= 16'h0000;
      cause_q <= slp_pkg::CAUSE_NONE;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_done_one_cycle: assert property (
    req_i.valid |=> rsp_q.done ##1 (rsp_q.done == $past(req_i.valid)))
    else $error("answer did not follow request");

  chk_access_zero_code: assert property (
    (req_i.valid && req_i.op == slp_pkg::OP_ACCESS) |=>
      (!rsp_q.err_sel && rsp_q.err_code == 16'h0000))
    else $error("offset fault carried a nonzero code");

  chk_load_selector: assert property (
    (req_i.valid && req_i.op == slp_pkg::OP_LOAD) |=>
      (!rsp_q.fault || (rsp_q.err_sel &&
       rsp_q.err_code == $past(req_i.selector))))
    else $error("load fault lost the selector");

  chk_stack_level: assert property (
    (req_i.valid && req_i.op == slp_pkg::OP_LOAD && prot_en_q &&
     req_i.seg == slp_pkg::SEG_SS &&
     descriptor_level != current_level) |=> rsp_q.fault)
    else $error("stack load at wrong level accepted");

  chk_fault_no_proceed: assert property (
    rsp_q.fault |-> (!rsp_q.proceed && !rsp_q.mark_accessed))
    else $error("faulting check let work proceed");

  chk_prefetch_quiet: assert property (
    (req_i.valid && req_i.op == slp_pkg::OP_ACCESS &&
     req_i.acc == slp_pkg::ACC_FETCH) |=> !rsp_q.fault)
    else $error("prefetch raised a fault");

  chk_levels_agree: assert property (
    seg_sel_q[slp_pkg::SEG_CS][1:0] == seg_sel_q[slp_pkg::SEG_SS][1:0])
    else $error("code and stack levels differ");

  chk_code_write: assert property (
    (req_i.valid && req_i.op == slp_pkg::OP_ACCESS && prot_en_q &&
     req_i.acc == slp_pkg::ACC_WRITE && c_acc[slp_pkg::AB_EXEC])
      |=> (rsp_q.fault && rsp_q.err_code == 16'h0000))
    else $error("write into code not refused");

  chk_requested_deny: assert property (
    (req_i.valid && req_i.op == slp_pkg::OP_LOAD && prot_en_q &&
     requested_level > descriptor_level) |=> rsp_q.fault)
    else $error("weaker requester was granted access");

  chk_wb_ack_pulse: assert property (
    (wb_cyc_i && wb_stb_i && !ack_q) |=> ack_q ##1 !ack_q)
    else $error("bus ack not a single pulse");

  chk_down_full: assert property (
    (req_i.valid && req_i.op == slp_pkg::OP_ACCESS && prot_en_q &&
     req_i.acc == slp_pkg::ACC_READ && expand_down && (&c_lim))
      |=> !rsp_q.fault)
    else $error("full expand-down segment refused a read");

  chk_exec_only_read: assert property (
    (req_i.valid && req_i.op == slp_pkg::OP_ACCESS && prot_en_q &&
     req_i.acc == slp_pkg::ACC_READ && c_acc[slp_pkg::AB_EXEC] &&
     !c_acc[slp_pkg::AB_RW]) |=> (rsp_q.fault && !rsp_q.err_sel))
    else $error("read of execute-only code not refused");

  chk_xfer_equal: assert property (
    (req_i.valid && req_i.op == slp_pkg::OP_XFER && prot_en_q &&
     req_i.xfer != slp_pkg::XF_RET && req_i.access[slp_pkg::AB_EXEC] &&
     !req_i.access[slp_pkg::AB_CONF_DOWN] &&
     descriptor_level != current_level) |=> rsp_q.fault)
    else $error("direct transfer across levels accepted");

endmodule : slp_check

// >>> dv/slp_fetch_model.sv
`timescale 1ns/100ps
module slp_fetch_model (
  input wire logic clk_i, // processor clock
  input wire slp_pkg::slp_req_type cmd_i, // request without descriptor
  input wire slp_pkg::slp_rsp_type rsp_i, // answer from the checker
  output slp_pkg::slp_req_type req_o // request with fetched descriptor
);
  logic [7:0] acc_q [8];
  logic [15:0] lim_q [8];
  logic [2:0] ix;

  task automatic put(input logic [2:0] i, input logic [7:0] a,
    input logic [15:0] l);
    acc_q[i] <= a;
    lim_q[i] <= l;
  endtask : put

  assign ix = cmd_i.selector[5:3];

  // descriptor lines carry junk outside a request, as on the real path
  always_comb
  begin
    req_o = cmd_i;
    req_o.access = cmd_i.valid ? acc_q[ix] : ~acc_q[ix];
    req_o.limit = cmd_i.valid ? lim_q[ix] : ~lim_q[ix];
  end

  always @(posedge clk_i)
  begin
    if (rsp_i.mark_accessed === 1'b1)
    begin
      acc_q[rsp_i.mark_selector[5:3]][0] <= 1'b1;
    end
  end
endmodule : slp_fetch_model

// >>> dv/segment_load_protection_check_tb_top.sv
`timescale 1ns/100ps
module segment_load_protection_check_tb_top;
  localparam slp_pkg::slp_op_type LD = slp_pkg::OP_LOAD;
  localparam slp_pkg::slp_op_type AC = slp_pkg::OP_ACCESS;
  localparam slp_pkg::slp_op_type XF = slp_pkg::OP_XFER;
  localparam slp_pkg::slp_acc_type RD = slp_pkg::ACC_READ;
  localparam slp_pkg::slp_acc_type WR = slp_pkg::ACC_WRITE;
  localparam slp_pkg::slp_acc_type EX = slp_pkg::ACC_EXEC;
  localparam slp_pkg::slp_acc_type FE = slp_pkg::ACC_FETCH;
  localparam slp_pkg::slp_xfer_type JP = slp_pkg::XF_JUMP;
  localparam slp_pkg::slp_xfer_type CL = slp_pkg::XF_CALL;
  localparam slp_pkg::slp_xfer_type RT = slp_pkg::XF_RET;
  localparam logic [1:0] DSR = slp_pkg::SEG_DATA;
  localparam logic [1:0] ESR = slp_pkg::SEG_EXTRA;
  localparam logic [1:0] SSR = slp_pkg::SEG_SS;
  localparam logic [1:0] CSR = slp_pkg::SEG_CS;
  localparam logic [7:0] STA = slp_pkg::REG_STATUS;
  localparam logic [7:0] CTL = slp_pkg::REG_CTRL;

  logic clk_i;
  logic rst_i;
  slp_pkg::slp_req_type cmd;
  slp_pkg::slp_req_type req;
  slp_pkg::slp_rsp_type rsp;
  slp_pkg::slp_rsp_type last;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat;
  int n_mismatch = 0;
  int total_checks = 0;

  slp_fetch_model m (.clk_i(clk_i), .cmd_i(cmd), .rsp_i(rsp), .req_o(req));

  slp_check dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rsp_o(rsp),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_ack_o(wb_ack), .wb_dat_o(wb_rdat));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // reads compare data; the answer edge is found by polling, never assumed
  task automatic wb(input logic we, input logic [7:0] adr,
    input logic [31:0] wd, input logic [31:0] exp, input string nm);
    int k;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wd;
    for (k = 0; k < 20 && wb_ack !== 1'b1; k++)
      @(posedge clk_i);
    if (wb_ack !== 1'b1)
    begin
      n_mismatch++;
      $display("[ERR] wb_ack expected 1 seen 0");
      complete_run();
    end
    if (!we)
      chk(nm, wb_rdat, exp);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  // e is {fault, proceed}; loads and transfers report the selector
  task automatic run(input slp_pkg::slp_op_type o, input logic [1:0] sg,
    input logic [15:0] sel, input logic [7:0] ab, input logic [15:0] lim,
    input logic [1:0] e, input logic [15:0] off = 16'h0000,
    input slp_pkg::slp_acc_type ak = RD,
    input slp_pkg::slp_xfer_type xf = JP);
    slp_pkg::slp_req_type c;
    logic ld;
    ld = (o != AC);
    c = '0;
    c.valid = 1'b1;
    c.op = o;
    c.seg = sg;
    c.selector = sel;
    c.offset = off;
    c.acc = ak;
    c.xfer = xf;
    @(posedge clk_i);
    if (ld)
      m.put(sel[5:3], ab, lim);
    cmd <= c;
    @(posedge clk_i);
    cmd.valid <= 1'b0;
    @(posedge clk_i);
    last = rsp;
    chk("done", last.done, 1'b1);
    chk("fault", last.fault, e[1]);
    chk("err_sel", last.err_sel, e[1] & ld);
    chk("err_code", last.err_code, (e[1] & ld) ? sel : 16'h0000);
    chk("proceed", last.proceed, e[0]);
    chk("marked", last.mark_accessed, ~e[1] & ld);
    chk("mark_sel", last.mark_selector, (~e[1] & ld) ? sel : 16'h0000);
  endtask : run

  task automatic t_bus();
    wb(1'b0, CTL, 32'h0, 32'h0000_0001, "ctrl");
    wb(1'b1, CTL, 32'h0, 32'h0, "");
    run(LD, DSR, 16'h0008, 8'hF9, 16'hFFFF, 2'h0);
    wb(1'b1, CTL, 32'h0000_0001, 32'h0, "");
    run(LD, DSR, 16'h0008, 8'hF9, 16'hFFFF, 2'h2);
    wb(1'b0, 8'h40, 32'h0, 32'h0, "unmapped");
    $display("t_bus finished");
  endtask : t_bus

  task automatic t_types();
    run(LD, DSR, 16'h0008, 8'hF2, 16'hFFFF, 2'h0);
    run(LD, ESR, 16'h0010, 8'hF1, 16'hFFFF, 2'h0);
    chk("accessed", m.acc_q[1][0], 1'b1);
    run(LD, DSR, 16'h0018, 8'hFB, 16'hFFFF, 2'h0);
    run(LD, ESR, 16'h0020, 8'hF9, 16'hFFFF, 2'h2);
    run(LD, DSR, 16'h0028, 8'h73, 16'hFFFF, 2'h2);
    run(LD, ESR, 16'h0030, 8'hE3, 16'hFFFF, 2'h2);
    run(LD, ESR, 16'h0038, 8'hF7, 16'h0010, 2'h0);
    run(LD, SSR, 16'h0038, 8'h91, 16'hFFFF, 2'h2);
    run(LD, SSR, 16'h0038, 8'h93, 16'hFFFF, 2'h0);
    run(LD, DSR, 16'h000A, 8'hB3, 16'hFFFF, 2'h2);
    run(LD, DSR, 16'h0008, 8'hB3, 16'hFFFF, 2'h0);
    $display("t_types finished");
  endtask : t_types

  task automatic t_limit();
    run(LD, DSR, 16'h0008, 8'h93, 16'h0010, 2'h0);
    run(AC, DSR, 16'h0, 8'h0, 16'h0, 2'h1, 16'h0010, RD);
    wb(1'b1, STA, 32'h0, 32'h0, "");
    run(AC, DSR, 16'h0, 8'h0, 16'h0, 2'h2, 16'h0011, WR);
    wb(1'b0, STA, 32'h0, {16'h0001, 13'h0, slp_pkg::CAUSE_LIMIT}, "st");
    run(LD, DSR, 16'h0008, 8'h97, 16'h0010, 2'h0);
    run(AC, DSR, 16'h0, 8'h0, 16'h0, 2'h2, 16'h0010, RD);
    run(AC, DSR, 16'h0, 8'h0, 16'h0, 2'h1, 16'h0011, WR);
    run(AC, DSR, 16'h0, 8'h0, 16'h0, 2'h1, 16'hFFFF, RD);
    run(LD, DSR, 16'h0008, 8'h97, 16'hFFFF, 2'h0);
    run(AC, DSR, 16'h0, 8'h0, 16'h0, 2'h1, 16'h0000, RD);
    $display("t_limit finished");
  endtask : t_limit

  task automatic t_code();
    run(XF, CSR, 16'h0010, 8'h98, 16'h0010, 2'h0, 16'h0, RD, JP);
    run(AC, CSR, 16'h0, 8'h0, 16'h0, 2'h2, 16'h0000, RD);
    run(AC, CSR, 16'h0, 8'h0, 16'h0, 2'h2, 16'h0000, WR);
    run(AC, CSR, 16'h0, 8'h0, 16'h0, 2'h1, 16'h0010, EX);
    run(AC, CSR, 16'h0, 8'h0, 16'h0, 2'h2, 16'h0011, EX);
    run(AC, CSR, 16'h0, 8'h0, 16'h0, 2'h0, 16'h0011, FE);
    $display("t_code finished");
  endtask : t_code

  task automatic t_xfer();
    run(XF, CSR, 16'h0018, 8'hFA, 16'hFFFF, 2'h2, 16'h0, RD, CL);
    run(XF, CSR, 16'h001B, 8'hFA, 16'hFFFF, 2'h0, 16'h0, RD, RT);
    chk("level", last.current_level, 2'h3);
    run(LD, DSR, 16'h0020, 8'hD3, 16'hFFFF, 2'h2);
    run(LD, SSR, 16'h0022, 8'hD3, 16'hFFFF, 2'h2);
    run(XF, CSR, 16'h0028, 8'h9E, 16'hFFFF, 2'h0, 16'h0, RD, JP);
    chk("level", last.current_level, 2'h3);
    run(XF, CSR, 16'h0030, 8'h9A, 16'hFFFF, 2'h2, 16'h0, RD, RT);
    wb(1'b0, slp_pkg::REG_CODE_STACK, 32'h0, 32'h003B_002B, "cs_ss");
    wb(1'b0, slp_pkg::REG_DATA_EXTRA, 32'h0, 32'h0038_0008, "ds_es");
    $display("t_xfer finished");
  endtask : t_xfer

  initial
  begin
    rst_i = 1'b1;
    cmd = '0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hF;
    wb_wdat = 32'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_bus();
    t_types();
    t_limit();
    t_code();
    t_xfer();
    complete_run();
  end
endmodule : segment_load_protection_check_tb_top
